// >>> verilog/disp_pkg.sv
package disp_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_W = 15;
  localparam int TEXT_STEP_S = 3;
  localparam int ROTATIONS = 3;
  localparam int DWELL_S = 27;
  localparam int BLINK_PERIOD_S = 2;
  localparam int WARN_ALT_S = 2;
  localparam int ZERO_HOLD_S = 1;
  localparam int INFO_STEP_S = 2;
  localparam int FEEDBACK_S = 2;
  localparam int DEBOUNCE_MS = 20;
  localparam logic [MS_W-1:0] TEXT_MS = MS_W'(TEXT_STEP_S * 1000);
  localparam logic [MS_W-1:0] BLINK_MS = MS_W'(BLINK_PERIOD_S * 500);
  localparam logic [MS_W-1:0] WARN_MS = MS_W'(WARN_ALT_S * 1000);
  localparam logic [MS_W-1:0] ZHOLD_MS = MS_W'(ZERO_HOLD_S * 1000);
  localparam logic [MS_W-1:0] INFO_MS = MS_W'(INFO_STEP_S * 1000);
  localparam logic [MS_W-1:0] FB_MS = MS_W'(FEEDBACK_S * 1000);
  localparam logic [MS_W-1:0] DB_MS = MS_W'(DEBOUNCE_MS);
  localparam int NUM_SLOTS = 4;
  localparam int CODE_W = 4;
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] SLOT_UNINIT = 5'h10;
  localparam logic [SLOT_W-1:0] CODE_TB_PV = 5'h00;
  localparam int VALUE_DIGITS = 5;
  localparam int TEXT_CHARS = 7;
  localparam logic [5:0] BAR_SEGS = 6'h32;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [1:0] COLD_SAMPLE_AT = 2'h2;
  typedef enum logic [3:0] {SCR_STATUS, SCR_TAG, SCR_UNIT, SCR_NEXT_TAG,
    SCR_ERROR, SCR_WARNING, SCR_ZERO_DONE, SCR_ZERO_REFUSED, SCR_SWITCHES,
    SCR_DEVICE_REVISION, SCR_DESCRIPTOR_REVISION, SCR_SELFTEST} scr_e;
endpackage

// >>> verilog/local_display_ctrl.sv
`timescale 1ns/100ps
module local_display_ctrl import disp_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST, // Synchronous reset, high
  input wire logic [3:0] SWITCH_PINS, // DIP switches 1..4, high = on
  input wire logic ZERO_BTN_PIN, // Zero button, high = pressed
  input wire logic INFO_BTN_PIN, // Info button, high = pressed
  input wire logic HW_LOCK_SUPPORTED, // Feature selection lock bit
  input wire logic CFG_WRITE_REQ, // Configuration write attempt
  input wire logic SIM_REQ, // Simulation requested
  input wire logic SELFTEST_DONE, // Power-up self-test finished
  input wire logic AUTOSCROLL_EN, // Auto-scroll enable
  input wire logic [2:0] SLOT_SELECT, // Slot selector 1..4
  input wire logic SLOT_WE, // Slot code write strobe
  input wire logic [1:0] SLOT_IDX, // Slot written
  input wire logic [SLOT_W-1:0] SLOT_DATA, // Code, 5'h10 = uninit
  input wire logic ERROR_PRESENT, // Error condition
  input wire logic WARNING_PRESENT, // Warning condition
  input wire logic [6:0] PCT_OUT_SCALE, // Percent of output scale
  input wire logic [6:0] PCT_SENSOR_RANGE, // Percent of sensor range
  output logic WRITE_LOCKED, // Lock in force
  output logic CFG_WRITE_REJECT, // Write attempt refused
  output logic SIM_ALLOWED, // Simulation permitted
  output logic LOAD_DEFAULTS, // Cold-start default load pulse
  output logic ZERO_ALIGN, // Zero value and low cal point pulse
  output logic [3:0] DISP_SCREEN, // Screen content selector
  output logic [CODE_W-1:0] DISP_VAR, // Variable code shown
  output logic DISP_BLANK, // Blink-off phase
  output logic DISP_ALL_ON, // All segments lit
  output logic [5:0] DISP_BAR, // Lit bargraph segments
  output logic [15:0] DISP_SW_DIGITS // Switch digits, switch 1 high
);
  logic [5:0] meta_q, sync_q;
  logic [$clog2(TICK_CYCLES)-1:0] pre_q;
  logic tick_q;
  logic [1:0] btn_q, btn_prev_q;
  logic lock;
  logic [1:0] start_q;
  logic [SLOT_W-1:0] slot_q [NUM_SLOTS];
  logic [1:0] cur_q, nxt;
  logic [MS_W-1:0] text_ms_q, blink_ms_q, warn_ms_q, zh_ms_q, fb_ms_q;
  logic [MS_W-1:0] info_ms_q;
  logic [1:0] phase_q, rot_q, info_q;
  logic trans_q, blink_q, warn_q, fb_q, fb_ok_q;
  logic text_end, z_rel, z_long;
  scr_e scr_d;
  logic [6:0] pct;

  // Two-stage synchronizers for switches and buttons
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= {INFO_BTN_PIN, ZERO_BTN_PIN, SWITCH_PINS};
      sync_q <= meta_q;
    end
  end

  // Millisecond tick
  always_ff @(posedge CORE_CLK) begin
    if (RST || pre_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
    tick_q <= !RST && pre_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
  end

  // Button debounce: level must hold steady for the debounce time
  for (genvar b = 0; b < 2; b++) begin : g_db
    logic [MS_W-1:0] db_q;
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        db_q <= '0;
        btn_q[b] <= 1'b0;
      end else if (sync_q[4+b] == btn_q[b]) begin
        db_q <= '0;
      end else if (tick_q) begin
        db_q <= db_q + 1'b1;
        if (db_q == DB_MS - 1'b1) begin
          btn_q[b] <= sync_q[4+b];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    btn_prev_q <= RST ? 2'h0 : btn_q;
  end

  // Write lock, rejection and simulation gate
  assign lock = sync_q[0] && HW_LOCK_SUPPORTED;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      WRITE_LOCKED <= 1'b0;
      CFG_WRITE_REJECT <= 1'b0;
      SIM_ALLOWED <= 1'b0;
    end else begin
      WRITE_LOCKED <= lock;
      CFG_WRITE_REJECT <= CFG_WRITE_REQ && lock;
      SIM_ALLOWED <= SIM_REQ && sync_q[1];
    end
  end

  // Cold-start switch caught once the synchronizer holds a real sample
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      start_q <= 2'h0;
      LOAD_DEFAULTS <= 1'b0;
    end else begin
      if (start_q != 2'h3) begin
        start_q <= start_q + 1'b1;
      end
      LOAD_DEFAULTS <= start_q == COLD_SAMPLE_AT && sync_q[2];
    end
  end

  // Selection slots; writes refused under lock
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_q[i] <= (i == 0) ? CODE_TB_PV : SLOT_UNINIT;
      end
    end else if (SLOT_WE && !lock) begin
      slot_q[SLOT_IDX] <= SLOT_DATA;
    end
  end

  // Next initialized slot after the current one
  always_comb begin
    nxt = cur_q;
    for (int i = 3; i >= 1; i--) begin
      if (slot_q[2'(cur_q + 2'(i))] != SLOT_UNINIT) begin
        nxt = 2'(cur_q + 2'(i));
      end
    end
  end

  assign text_end = tick_q && text_ms_q == TEXT_MS - 1'b1;

  // Text rotation, rotation count and slot stepping
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      text_ms_q <= '0;
      phase_q <= 2'h0;
      rot_q <= 2'h0;
      trans_q <= 1'b0;
      cur_q <= 2'h0;
    end else begin
      if (tick_q) begin
        text_ms_q <= text_end ? '0 : text_ms_q + 1'b1;
      end
      if (!AUTOSCROLL_EN) begin
        trans_q <= 1'b0;
        rot_q <= 2'h0;
        if (SLOT_SELECT >= 3'h1 && SLOT_SELECT <= 3'h4) begin
          cur_q <= 2'(SLOT_SELECT - 3'h1);
        end
      end
      if (text_end) begin
        if (trans_q) begin
          trans_q <= 1'b0;
          phase_q <= 2'h0;
          rot_q <= 2'h0;
          cur_q <= nxt;
        end else if (phase_q == 2'h2) begin
          phase_q <= 2'h0;
          rot_q <= rot_q + 1'b1;
          if (AUTOSCROLL_EN && rot_q == 2'(ROTATIONS - 1)) begin
            trans_q <= 1'b1;
          end
        end else begin
          phase_q <= phase_q + 1'b1;
        end
      end
    end
  end

  // Error blink and warning alternation timers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      blink_ms_q <= '0;
      warn_ms_q <= '0;
      blink_q <= 1'b0;
      warn_q <= 1'b0;
    end else if (tick_q) begin
      blink_ms_q <= blink_ms_q + 1'b1;
      warn_ms_q <= warn_ms_q + 1'b1;
      if (blink_ms_q == BLINK_MS - 1'b1) begin
        blink_ms_q <= '0;
        blink_q <= !blink_q;
      end
      if (warn_ms_q == WARN_MS - 1'b1) begin
        warn_ms_q <= '0;
        warn_q <= !warn_q;
      end
    end
  end

  assign z_rel = btn_prev_q[0] && !btn_q[0];
  assign z_long = zh_ms_q > ZHOLD_MS;

  // Zero button hold timing, alignment and feedback
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      zh_ms_q <= '0;
      fb_ms_q <= '0;
      fb_q <= 1'b0;
      fb_ok_q <= 1'b0;
      ZERO_ALIGN <= 1'b0;
    end else begin
      ZERO_ALIGN <= z_rel && z_long && !lock;
      if (!btn_q[0]) begin
        zh_ms_q <= '0;
      end else if (tick_q && !zh_ms_q[MS_W-1]) begin
        zh_ms_q <= zh_ms_q + 1'b1;
      end
      if (z_rel && z_long) begin
        fb_q <= 1'b1;
        fb_ok_q <= !lock;
        fb_ms_q <= '0;
      end else if (tick_q && fb_q) begin
        fb_ms_q <= fb_ms_q + 1'b1;
        fb_q <= fb_ms_q != FB_MS - 1'b1;
      end
    end
  end

  // Info button screen sequence
  always_ff @(posedge CORE_CLK) begin
    if (RST || !btn_q[1]) begin
      info_ms_q <= '0;
      info_q <= 2'h0;
    end else if (tick_q) begin
      info_ms_q <= info_ms_q + 1'b1;
      if (info_ms_q == INFO_MS - 1'b1) begin
        info_ms_q <= '0;
        info_q <= (info_q == 2'h2) ? 2'h0 : info_q + 1'b1;
      end
    end
  end

  // Screen priority
  always_comb begin
    scr_d = scr_e'(phase_q);
    if (!SELFTEST_DONE) begin
      scr_d = SCR_SELFTEST;
    end else if (ERROR_PRESENT) begin
      scr_d = SCR_ERROR;
    end else if (fb_q) begin
      scr_d = fb_ok_q ? SCR_ZERO_DONE : SCR_ZERO_REFUSED;
    end else if (btn_q[1]) begin
      scr_d = scr_e'(4'(SCR_SWITCHES) + 4'(info_q));
    end else if (WARNING_PRESENT && warn_q) begin
      scr_d = SCR_WARNING;
    end else if (trans_q) begin
      scr_d = SCR_NEXT_TAG;
    end
  end

  // Bargraph percent source and clamp
  always_comb begin
    pct = (slot_q[cur_q] == CODE_TB_PV) ? PCT_SENSOR_RANGE : PCT_OUT_SCALE;
    if (pct > PCT_FULL) begin
      pct = PCT_FULL;
    end
  end

  // Display outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DISP_SCREEN <= 4'(SCR_SELFTEST);
      DISP_VAR <= CODE_W'(CODE_TB_PV);
      DISP_BLANK <= 1'b0;
      DISP_ALL_ON <= 1'b1;
      DISP_BAR <= 6'h00;
      DISP_SW_DIGITS <= 16'h0000;
    end else begin
      DISP_SCREEN <= 4'(scr_d);
      DISP_VAR <= CODE_W'(trans_q ? slot_q[nxt] : slot_q[cur_q]);
      DISP_BLANK <= scr_d == SCR_ERROR && blink_q;
      DISP_ALL_ON <= !SELFTEST_DONE;
      DISP_BAR <= 6'(pct >> 1);
      for (int i = 0; i < 4; i++) begin
        DISP_SW_DIGITS[15-4*i -: 4] <= {3'h0, sync_q[i]};
      end
    end
  end

  sequence s_single;
    !AUTOSCROLL_EN && SLOT_SELECT == 3'h3;
  endsequence
  sequence s_long_release;
    z_rel && z_long && !lock;
  endsequence

  property p_lock_reject;
    @(posedge CORE_CLK) disable iff (RST)
      CFG_WRITE_REQ && sync_q[0] && HW_LOCK_SUPPORTED |=> CFG_WRITE_REJECT;
  endproperty
  a_lock_reject: assert property (p_lock_reject)
    else $error("Locked write not rejected");
  property p_lock_unsupported;
    @(posedge CORE_CLK) disable iff (RST)
      !HW_LOCK_SUPPORTED |=> !WRITE_LOCKED && !CFG_WRITE_REJECT;
  endproperty
  a_lock_unsupported: assert property (p_lock_unsupported)
    else $error("Lock active without support bit");
  property p_sim;
    @(posedge CORE_CLK) disable iff (RST) SIM_ALLOWED |-> $past(sync_q[1]);
  endproperty
  a_sim: assert property (p_sim)
    else $error("Simulation allowed with switch off");
  property p_cold;
    @(posedge CORE_CLK) disable iff (RST)
      LOAD_DEFAULTS |-> $past(start_q) == COLD_SAMPLE_AT;
  endproperty
  a_cold: assert property (p_cold)
    else $error("Default load outside power-up");
  property p_single;
    @(posedge CORE_CLK) disable iff (RST)
      s_single ##1 s_single |-> cur_q == 2'h2;
  endproperty
  a_single: assert property (p_single)
    else $error("Single mode shows wrong slot");
  property p_error;
    @(posedge CORE_CLK) disable iff (RST)
      SELFTEST_DONE && ERROR_PRESENT |=> DISP_SCREEN == 4'(SCR_ERROR);
  endproperty
  a_error: assert property (p_error)
    else $error("Error not overriding display");
  property p_zero_long;
    @(posedge CORE_CLK) disable iff (RST)
      s_long_release |=> ZERO_ALIGN ##1 !ZERO_ALIGN;
  endproperty
  a_zero_long: assert property (p_zero_long)
    else $error("Zero alignment not issued once");
  property p_zero_short;
    @(posedge CORE_CLK) disable iff (RST)
      z_rel && !z_long |=> !ZERO_ALIGN;
  endproperty
  a_zero_short: assert property (p_zero_short)
    else $error("Short zero press acted on");
  property p_selftest;
    @(posedge CORE_CLK) disable iff (RST)
      !SELFTEST_DONE |=> DISP_ALL_ON && DISP_SCREEN == 4'(SCR_SELFTEST);
  endproperty
  a_selftest: assert property (p_selftest)
    else $error("Segments not lit in self-test");
  property p_bar;
    @(posedge CORE_CLK) disable iff (RST) DISP_BAR <= BAR_SEGS;
  endproperty
  a_bar: assert property (p_bar)
    else $error("Bargraph beyond segment count");
endmodule

// >>> verification/operator_model.sv
`timescale 1ns/100ps
module operator_model #(
  parameter int TK = 4
) (
  input wire logic CORE_CLK, // Core clock
  output logic [3:0] SWITCH_PINS, // DIP switches, high = on
  output logic ZERO_BTN_PIN, // Zero button, high = pressed
  output logic INFO_BTN_PIN // Info button, high = pressed
);
  // Cold start switch on at power-up, buttons released
  initial begin
    SWITCH_PINS = 4'h4;
    ZERO_BTN_PIN = 1'b0;
    INFO_BTN_PIN = 1'b0;
  end
  // Switch flip by hand
  task automatic set_sw(input logic [3:0] v);
    @(posedge CORE_CLK);
    #1;
    SWITCH_PINS = v;
  endtask
  // One contact level on the chosen button
  task automatic drv(input bit info, input logic v);
    @(posedge CORE_CLK);
    #1;
    if (info) begin
      INFO_BTN_PIN = v;
    end else begin
      ZERO_BTN_PIN = v;
    end
  endtask
  // Press with contact chatter, hold, release with chatter
  task automatic press(input bit info, input int ticks);
    for (int i = 0; i < 6; i++) drv(info, i[0]); // Chatter on press
    repeat (ticks * TK) @(posedge CORE_CLK);
    for (int i = 0; i < 6; i++) drv(info, ~i[0]);
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import disp_pkg::*;
  localparam int TK = 4;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] SWITCH_PINS;
  logic ZERO_BTN_PIN;
  logic INFO_BTN_PIN;
  logic HW_LOCK_SUPPORTED = 1'b0;
  logic CFG_WRITE_REQ = 1'b0;
  logic SIM_REQ = 1'b0;
  logic SELFTEST_DONE = 1'b0;
  logic AUTOSCROLL_EN = 1'b0;
  logic [2:0] SLOT_SELECT = 3'h1;
  logic SLOT_WE = 1'b0;
  logic [1:0] SLOT_IDX = 2'h0;
  logic [SLOT_W-1:0] SLOT_DATA = 5'h00;
  logic ERROR_PRESENT = 1'b0;
  logic WARNING_PRESENT = 1'b0;
  logic [6:0] PCT_SENSOR_RANGE = 7'h00;
  logic [6:0] PCT_OUT_SCALE = 7'h14;
  logic WRITE_LOCKED, CFG_WRITE_REJECT, SIM_ALLOWED, LOAD_DEFAULTS;
  logic ZERO_ALIGN, DISP_BLANK, DISP_ALL_ON;
  logic [3:0] DISP_SCREEN;
  logic [CODE_W-1:0] DISP_VAR;
  logic [5:0] DISP_BAR;
  logic [15:0] DISP_SW_DIGITS;
  int num_errors = 0;
  int compares = 0;
  int ld_n = 0;
  int zp_n = 0;
  int n;
  logic [3:0] s;
  logic b;
  // sw1 sw2 support cfg sim | locked reject sim_ok
  logic [7:0] rows [8] = '{8'hB6, 8'h90, 8'h30, 8'hED, 8'h49, 8'h08,
    8'hD9, 8'h60};

  always #2 CORE_CLK = ~CORE_CLK;

  operator_model #(.TK(TK)) u_operator_model (.CORE_CLK(CORE_CLK),
    .SWITCH_PINS(SWITCH_PINS), .ZERO_BTN_PIN(ZERO_BTN_PIN),
    .INFO_BTN_PIN(INFO_BTN_PIN));

  local_display_ctrl #(.TICK_CYCLES(TK)) u_local_display_ctrl (
    .CORE_CLK(CORE_CLK), .RST(RST), .SWITCH_PINS(SWITCH_PINS),
    .ZERO_BTN_PIN(ZERO_BTN_PIN), .INFO_BTN_PIN(INFO_BTN_PIN),
    .HW_LOCK_SUPPORTED(HW_LOCK_SUPPORTED), .CFG_WRITE_REQ(CFG_WRITE_REQ),
    .SIM_REQ(SIM_REQ), .SELFTEST_DONE(SELFTEST_DONE),
    .AUTOSCROLL_EN(AUTOSCROLL_EN), .SLOT_SELECT(SLOT_SELECT),
    .SLOT_WE(SLOT_WE), .SLOT_IDX(SLOT_IDX), .SLOT_DATA(SLOT_DATA),
    .ERROR_PRESENT(ERROR_PRESENT), .WARNING_PRESENT(WARNING_PRESENT),
    .PCT_OUT_SCALE(PCT_OUT_SCALE), .PCT_SENSOR_RANGE(PCT_SENSOR_RANGE),
    .WRITE_LOCKED(WRITE_LOCKED), .CFG_WRITE_REJECT(CFG_WRITE_REJECT),
    .SIM_ALLOWED(SIM_ALLOWED), .LOAD_DEFAULTS(LOAD_DEFAULTS),
    .ZERO_ALIGN(ZERO_ALIGN), .DISP_SCREEN(DISP_SCREEN), .DISP_VAR(DISP_VAR),
    .DISP_BLANK(DISP_BLANK), .DISP_ALL_ON(DISP_ALL_ON), .DISP_BAR(DISP_BAR),
    .DISP_SW_DIGITS(DISP_SW_DIGITS));

  // Pulse counters for one-cycle outputs
  always @(posedge CORE_CLK) begin
    if (LOAD_DEFAULTS === 1'b1) ld_n++;
    if (ZERO_ALIGN === 1'b1) zp_n++;
  end

  task automatic step();
    @(posedge CORE_CLK);
    #1;
  endtask
  task automatic wt(input int ticks);
    repeat (ticks * TK) step();
  endtask
  task automatic chk(input string nm, input logic [15:0] e, got);
    compares++;
    if (got !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask
  task automatic wr_slot(input logic [1:0] i, input logic [4:0] d);
    SLOT_IDX = i;
    SLOT_DATA = d;
    SLOT_WE = 1'b1;
    step();
    SLOT_WE = 1'b0;
    repeat (4) step();
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (96000) @(posedge CORE_CLK);
    num_errors++;
    $display("Watchdog expired");
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge CORE_CLK);
    #1;
    RST = 1'b0;
    repeat (8) step();
    chk("LOAD_DEFAULTS count", 16'(ld_n), 16'h1);
    chk("DISP_ALL_ON", 16'h1, DISP_ALL_ON);
    chk("DISP_SCREEN selftest", 16'hB, DISP_SCREEN);
    done("reset");
    // Lock and simulation gating table
    for (int r = 0; r < 8; r++) begin
      u_operator_model.set_sw({2'b00, rows[r][6], rows[r][7]});
      HW_LOCK_SUPPORTED = rows[r][5];
      CFG_WRITE_REQ = rows[r][4];
      SIM_REQ = rows[r][3];
      repeat (5) step();
      chk("WRITE_LOCKED", 16'(rows[r][2]), WRITE_LOCKED);
      chk("CFG_WRITE_REJECT", 16'(rows[r][1]), CFG_WRITE_REJECT);
      chk("SIM_ALLOWED", 16'(rows[r][0]), SIM_ALLOWED);
    end
    CFG_WRITE_REQ = 1'b0;
    SIM_REQ = 1'b0;
    HW_LOCK_SUPPORTED = 1'b0;
    u_operator_model.set_sw(4'h0);
    done("gating");
    PCT_SENSOR_RANGE = 7'h4B;
    SELFTEST_DONE = 1'b1;
    repeat (4) step();
    chk("DISP_ALL_ON off", 16'h0, DISP_ALL_ON);
    chk("DISP_VAR default", 16'h0, DISP_VAR);
    chk("DISP_BAR 75", 16'h25, DISP_BAR);
    PCT_SENSOR_RANGE = 7'h64;
    repeat (4) step();
    chk("DISP_BAR 100", 16'h32, DISP_BAR);
    // Align to a text phase change, then time the next one
    s = DISP_SCREEN;
    n = 0;
    while (DISP_SCREEN === s && n < 3100 * TK) begin
      step();
      n++;
    end
    s = DISP_SCREEN;
    wt(2950);
    chk("text hold", 16'(s), DISP_SCREEN);
    wt(100);
    chk("text next", 16'(s == 4'h2 ? 4'h0 : s + 4'h1), DISP_SCREEN);
    done("display");
    wr_slot(2'h2, 5'h05);
    SLOT_SELECT = 3'h3;
    repeat (4) step();
    chk("DISP_VAR slot 3", 16'h5, DISP_VAR);
    chk("DISP_BAR out scale", 16'h0A, DISP_BAR);
    PCT_OUT_SCALE = 7'h7F;
    repeat (4) step();
    chk("DISP_BAR clamp", 16'h32, DISP_BAR);
    u_operator_model.set_sw(4'h1);
    HW_LOCK_SUPPORTED = 1'b1;
    repeat (4) step();
    wr_slot(2'h2, 5'h09);
    chk("DISP_VAR locked write", 16'h5, DISP_VAR);
    u_operator_model.set_sw(4'h0);
    HW_LOCK_SUPPORTED = 1'b0;
    AUTOSCROLL_EN = 1'b1;
    repeat (4) step();
    s = DISP_VAR;
    SLOT_SELECT = 3'h1;
    repeat (8) step();
    chk("DISP_VAR auto", 16'(s), DISP_VAR);
    AUTOSCROLL_EN = 1'b0;
    done("slots");
    ERROR_PRESENT = 1'b1;
    WARNING_PRESENT = 1'b1;
    repeat (4) step();
    chk("error screen", 16'h4, DISP_SCREEN);
    b = DISP_BLANK;
    wt(1000);
    chk("error blink", 16'(!b), DISP_BLANK);
    ERROR_PRESENT = 1'b0;
    repeat (4) step();
    s = DISP_SCREEN;
    wt(2000);
    chk("warn alternate", 16'(s != 4'h5), 16'(DISP_SCREEN == 4'h5));
    WARNING_PRESENT = 1'b0;
    done("diagnostics");
    u_operator_model.set_sw(4'h5);
    fork
      u_operator_model.press(1'b1, 5100);
      begin
        wt(1000);
        chk("info switches", 16'h8, DISP_SCREEN);
        chk("switch digits", 16'h1010, DISP_SW_DIGITS);
        wt(2000);
        chk("info device_revision", 16'h9, DISP_SCREEN);
        wt(2000);
        chk("info descriptor_revision", 16'hA, DISP_SCREEN);
      end
    join
    u_operator_model.set_sw(4'h0);
    wt(50);
    done("info");
    u_operator_model.press(1'b0, 500);
    wt(40);
    chk("short press pulses", 16'(zp_n), 16'h0);
    chk("short press screen", 16'h0, 16'(DISP_SCREEN inside {4'h6, 4'h7}));
    u_operator_model.press(1'b0, 1200);
    wt(40);
    chk("zero pulses", 16'(zp_n), 16'h1);
    chk("zero feedback", 16'h6, DISP_SCREEN);
    wt(2000);
    u_operator_model.set_sw(4'h1);
    HW_LOCK_SUPPORTED = 1'b1;
    u_operator_model.press(1'b0, 1200);
    wt(40);
    chk("locked zero pulses", 16'(zp_n), 16'h1);
    chk("locked zero feedback", 16'h7, DISP_SCREEN);
    done("zero");
    // Second reset with the cold-start switch off
    u_operator_model.set_sw(4'h0);
    repeat (4) step();
    RST = 1'b1;
    repeat (2) step();
    RST = 1'b0;
    repeat (8) step();
    chk("LOAD_DEFAULTS cold off", 16'(ld_n), 16'h1);
    chk("DISP_ALL_ON after reset", 16'h0, DISP_ALL_ON);
    chk("DISP_SCREEN after reset", 16'h0, DISP_SCREEN);
    done("reset again");
    end_of_test();
  end
endmodule
